// >>> hw/cpm_pkg.sv
// Shared types and constants for the control port pin function mux.
package cpm_pkg;

    // Number of port pins and fixed pin positions (zero based).
    localparam int NPINS       = 7;
    localparam int FAULT_PIN   = 0;
    localparam int RETURN_PIN  = 1;
    localparam int INHIBIT_PIN = 2;
    localparam int SYNC_LO     = 3;
    localparam int SYNC_HI     = 6;

    // Pin functions; the code is also the abbreviated readback code.
    typedef enum logic [2:0] {
        FN_GENERAL_IO,
        FN_INPUT_ONLY,
        FN_TRIGGER_OUT,
        FN_TRIGGER_IN,
        FN_FAULT_OUT,
        FN_INHIBIT_IN,
        FN_CHASSIS_ON_SYNC,
        FN_CHASSIS_OFF_SYNC
    } cpm_func_t;

    typedef enum logic {
        POL_POSITIVE,
        POL_NEGATIVE
    } cpm_pol_t;

    typedef struct packed {
        cpm_func_t func;
        cpm_pol_t  pol;
    } cpm_pin_cfg_t;

    // Whole persistent configuration image, one entry per pin.
    typedef cpm_pin_cfg_t [NPINS-1:0] cpm_cfg_img_t;

    // Reset values.
    localparam cpm_pin_cfg_t CFG_RESET    = '{FN_GENERAL_IO, POL_POSITIVE};
    localparam logic [6:0]   DATA_RESET   = 7'h00;
    localparam logic         BUS_EN_RESET = 1'b0;

    // Chassis coupling pins assert by pulling low, so linked pins wire-OR.
    localparam logic SYNC_TRUE_LEVEL = 1'b0;

    // Source select value that names no pin.
    localparam logic [2:0] SRC_NONE = 3'h7;

    // Trigger output pulse width.
    localparam int CLK_PERIOD_NS  = 20;
    localparam int TRIG_PULSE_NS  = 1000;
    localparam int TRIG_PULSE_CYC = (TRIG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// >>> hw/cpm_pin_cell.sv
// One port pin: driver, receiver and trigger edge logic.
`timescale 1ns/100ps
module cpm_pin_cell
    import cpm_pkg::*;
#(
    parameter logic FAULT_CAPABLE = 1'b0,          // Pin may drive fault.
    parameter int   PULSE_CYC     = TRIG_PULSE_CYC // Trigger width.
) (
    input  wire logic         clk,        // System clock.
    input  wire logic         rst,        // Sync reset, high.
    input  wire cpm_pin_cfg_t cfg,        // Effective config.
    input  wire logic         data_bit,   // Output data bit.
    input  wire logic         trig_fire,  // Trigger request pulse.
    input  wire logic         fault_true, // Any channel protected.
    input  wire logic         sync_on,    // Local on state.
    input  wire logic         sync_off,   // Local off state.
    input  wire logic         pin_in,     // Pin level.
    output logic              pin_out,    // Pin drive level.
    output logic              pin_oe_n,   // Low while driving.
    output logic              trig_edge,  // Active edge seen.
    output logic              true_lvl    // Logical true at pin.
);

    localparam int CW = $clog2(PULSE_CYC + 1);

    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic          prev;
    logic          next_out;
    logic          next_oe_n;
    logic          next_edge;
    logic          next_true;
    logic          neg;

    // Per-function drive and receive decisions.
    always_comb begin
        neg       = (cfg.pol == POL_NEGATIVE);
        next_cnt  = '0;
        next_out  = 1'b0;
        next_oe_n = 1'b1;
        next_edge = 1'b0;
        next_true = pin_in ^ neg;
        case (cfg.func)
            FN_GENERAL_IO: begin
                next_oe_n = 1'b0;
                next_out  = data_bit ^ neg;
            end
            // pulse only on a gated request.
            FN_TRIGGER_OUT: begin
                if (trig_fire) begin
                    next_cnt = CW'(PULSE_CYC);
                end else if (cnt != '0) begin
                    next_cnt = cnt - CW'(1);
                end
                next_oe_n = 1'b0;
                next_out  = (next_cnt != '0) ^ neg;
            end
            FN_TRIGGER_IN: begin
                next_edge = neg ? (prev & ~pin_in) : (~prev & pin_in);
            end
            FN_FAULT_OUT: begin
                if (FAULT_CAPABLE) begin
                    next_oe_n = 1'b0;
                    next_out  = fault_true ^ neg;
                end
            end
            FN_CHASSIS_ON_SYNC: begin
                next_out  = SYNC_TRUE_LEVEL;
                next_oe_n = ~sync_on;
                next_true = (pin_in == SYNC_TRUE_LEVEL);
            end
            FN_CHASSIS_OFF_SYNC: begin
                next_out  = SYNC_TRUE_LEVEL;
                next_oe_n = ~sync_off;
                next_true = (pin_in == SYNC_TRUE_LEVEL);
            end
            default: begin
                next_oe_n = 1'b1;
            end
        endcase
    end

    // Registered pin state; a released pin never glitches low at reset.
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt       <= '0;
            prev      <= 1'b0;
            pin_out   <= 1'b0;
            pin_oe_n  <= 1'b1;
            trig_edge <= 1'b0;
            true_lvl  <= 1'b0;
        end else begin
            cnt       <= next_cnt;
            prev      <= pin_in;
            pin_out   <= next_out;
            pin_oe_n  <= next_oe_n;
            trig_edge <= next_edge;
            true_lvl  <= next_true;
        end
    end

endmodule

// >>> hw/cpm_port.sv
// Control port pin function mux: configuration, routing and pin drive.
// Contract
// - one stored function per pin, persistent
// - general pin drives data, reads back
// - input only pin ignores output data
// - trigger out only on enabled sequencer or bus request
// - trigger in feeds acquire and transient
// - only pin one shows channel faults
// - fault locks pin two, reads fault
// - leaving fault sets pin two input
// - only pin three inhibits all channels
// - one on-coupling pin among four to seven
// - one off-coupling pin among four to seven
// - second on-coupling assignment is rejected
// - positive polarity means high, rising
// - negative polarity means low, falling
// - one stored polarity per pin, persistent
// - enabled bus trigger fires trigger outputs
// - readback gives function and polarity codes
// - seven bit output data, reset zero
// - input data shows real pin levels
`timescale 1ns/100ps
module cpm_port
    import cpm_pkg::*;
#(
    parameter int NCH = 4 // Output channel count.
) (
    input  wire logic           clk,           // System clock.
    input  wire logic           rst,           // Sync reset, high.
    input  wire logic           func_wr,       // Function write pulse.
    input  wire logic [2:0]     wr_pin,        // Target pin index.
    input  wire cpm_func_t      wr_func,       // Function to write.
    input  wire logic           pol_wr,        // Polarity write pulse.
    input  wire cpm_pol_t       wr_pol,        // Polarity to write.
    output logic                wr_reject,     // Write refused.
    input  wire logic [2:0]     rd_pin,        // Readback pin index.
    output cpm_func_t           rd_func,       // Function code read.
    output cpm_pol_t            rd_pol,        // Polarity code read.
    input  wire logic           nv_load,       // Restore pulse.
    input  wire cpm_cfg_img_t   nv_cfg_in,     // Stored image.
    output cpm_cfg_img_t        nv_cfg,        // Image to store.
    output logic                nv_save,       // Image changed.
    input  wire logic           data_wr,       // Data write pulse.
    input  wire logic [6:0]     data_val,      // Output data value.
    output logic [6:0]          out_data,      // Last data written.
    output logic [6:0]          in_data,       // Pin levels.
    input  wire logic           bus_en_wr,     // Bus enable write.
    input  wire logic           bus_en_val,    // Bus enable value.
    output logic                bus_trg_en,    // Bus trigger enable.
    input  wire logic           bus_trg,       // Software trigger.
    input  wire logic           seq_tout_en,   // Sequencer emits.
    input  wire logic           seq_trig,      // Sequencer trigger.
    input  wire logic [2:0]     acq_src,       // Acquire source pin.
    input  wire logic [2:0]     tran_src,      // Transient source pin.
    output logic                acq_trig,      // Acquire trigger.
    output logic                tran_trig,     // Transient trigger.
    input  wire logic [NCH-1:0] chan_prot,     // Channels protected.
    output logic                inhibit_out,   // Disable all outputs.
    input  wire logic           local_on,      // Local outputs on.
    input  wire logic           local_off,     // Local outputs off.
    output logic                sync_on_seen,  // Linked on state.
    output logic                sync_off_seen, // Linked off state.
    input  wire logic [6:0]     pin_in,        // Pin levels.
    output logic [6:0]          pin_out,       // Pin drive levels.
    output logic [6:0]          pin_oe_n       // Low while driving.
);

    cpm_cfg_img_t cfg_q;
    cpm_cfg_img_t next_cfg;
    cpm_cfg_img_t eff;
    logic         next_reject;
    logic         next_save;
    logic [6:0]   next_data;
    logic         next_bus_en;
    cpm_func_t    next_rd_func;
    cpm_pol_t     next_rd_pol;
    logic         next_acq;
    logic         next_tran;
    logic         next_inhibit;
    logic         next_on_seen;
    logic         next_off_seen;
    logic         trig_fire;
    logic         fault_true;
    logic [6:0]   edge_seen;
    logic [6:0]   true_lvl;
    logic [6:0]   on_mask;

    // Legality of a function write against the present image.
    function automatic logic func_ok(input logic [2:0] p, input cpm_func_t f,
                                     input cpm_cfg_img_t img);
        logic ok;
        ok = (p < 3'(NPINS));
        if (p == 3'(RETURN_PIN) && img[FAULT_PIN].func == FN_FAULT_OUT) begin
            ok = 1'b0;
        end
        if (f == FN_FAULT_OUT && p != 3'(FAULT_PIN)) begin
            ok = 1'b0;
        end
        if (f == FN_INHIBIT_IN && p != 3'(INHIBIT_PIN)) begin
            ok = 1'b0;
        end
        if (f == FN_CHASSIS_ON_SYNC || f == FN_CHASSIS_OFF_SYNC) begin
            if (p < 3'(SYNC_LO) || p > 3'(SYNC_HI)) begin
                ok = 1'b0;
            end
            for (int j = 0; j < NPINS; j++) begin
                if (img[j].func == f && 3'(j) != p) begin
                    ok = 1'b0;
                end
            end
        end
        return ok;
    endfunction

    // Legality of a polarity write; pin two is locked under fault.
    function automatic logic pol_ok(input logic [2:0] p, input cpm_cfg_img_t img);
        logic ok;
        ok = (p < 3'(NPINS));
        if (p == 3'(RETURN_PIN) && img[FAULT_PIN].func == FN_FAULT_OUT) begin
            ok = 1'b0;
        end
        return ok;
    endfunction

    // A selected pin fires only when it is a trigger input with an edge.
    function automatic logic src_fire(input logic [2:0] s, input cpm_cfg_img_t img,
                                      input logic [6:0] edges);
        logic hit;
        hit = 1'b0;
        if (s != SRC_NONE) begin
            hit = (img[s].func == FN_TRIGGER_IN) && edges[s];
        end
        return hit;
    endfunction

    // pin two acts as fault return.
    always_comb begin
        eff = cfg_q;
        if (cfg_q[FAULT_PIN].func == FN_FAULT_OUT) begin
            eff[RETURN_PIN].func = FN_FAULT_OUT;
        end
    end

    // Configuration updates; a restore from storage overrides a write.
    always_comb begin
        next_cfg    = cfg_q;
        next_reject = 1'b0;
        next_save   = 1'b0;
        if (nv_load) begin
            next_cfg = nv_cfg_in;
        end else begin
            if (func_wr) begin
                if (func_ok(wr_pin, wr_func, cfg_q)) begin
                    if (wr_pin == 3'(FAULT_PIN) && cfg_q[FAULT_PIN].func == FN_FAULT_OUT
                        && wr_func != FN_FAULT_OUT) begin
                        next_cfg[RETURN_PIN].func = FN_INPUT_ONLY;
                    end
                    next_cfg[wr_pin].func = wr_func;
                    next_save = 1'b1;
                end else begin
                    next_reject = 1'b1;
                end
            end
            if (pol_wr) begin
                if (pol_ok(wr_pin, cfg_q)) begin
                    next_cfg[wr_pin].pol = wr_pol;
                    next_save = 1'b1;
                end else begin
                    next_reject = 1'b1;
                end
            end
        end
    end

    // Image register; storage sees every accepted change through nv_save.
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_q     <= {NPINS{CFG_RESET}};
            wr_reject <= 1'b0;
            nv_save   <= 1'b0;
        end else begin
            cfg_q     <= next_cfg;
            wr_reject <= next_reject;
            nv_save   <= next_save;
        end
    end

    assign nv_cfg = cfg_q;

    // Output data and bus trigger enable.
    always_comb begin
        next_data   = out_data;
        next_bus_en = bus_trg_en;
        if (data_wr) begin
            next_data = data_val;
        end
        if (bus_en_wr) begin
            next_bus_en = bus_en_val;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            out_data   <= DATA_RESET;
            bus_trg_en <= BUS_EN_RESET;
        end else begin
            out_data   <= next_data;
            bus_trg_en <= next_bus_en;
        end
    end

    always_comb begin
        next_rd_func = FN_GENERAL_IO;
        next_rd_pol  = POL_POSITIVE;
        if (rd_pin < 3'(NPINS)) begin
            next_rd_func = eff[rd_pin].func;
            next_rd_pol  = eff[rd_pin].pol;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rd_func <= FN_GENERAL_IO;
            rd_pol  <= POL_POSITIVE;
        end else begin
            rd_func <= next_rd_func;
            rd_pol  <= next_rd_pol;
        end
    end

    assign trig_fire  = (seq_trig & seq_tout_en) | (bus_trg & bus_trg_en);
    assign fault_true = |chan_prot;

    // Pin cells; the effective image hides pin two while it is a return.
    for (genvar i = 0; i < NPINS; i++) begin : g_pin
        cpm_pin_cell #(
            .FAULT_CAPABLE (i == FAULT_PIN),
            .PULSE_CYC     (TRIG_PULSE_CYC)
        ) u_cell (
            .clk        (clk),
            .rst        (rst),
            .cfg        (eff[i]),
            .data_bit   (out_data[i]),
            .trig_fire  (trig_fire),
            .fault_true (fault_true),
            .sync_on    (local_on),
            .sync_off   (local_off),
            .pin_in     (pin_in[i]),
            .pin_out    (pin_out[i]),
            .pin_oe_n   (pin_oe_n[i]),
            .trig_edge  (edge_seen[i]),
            .true_lvl   (true_lvl[i])
        );
    end

    // Received levels and triggers; all but in_data come one cycle after the cell flops, in_data one cycle after pin_in.
    always_comb begin
        next_on_seen  = 1'b0;
        next_off_seen = 1'b0;
        for (int j = 0; j < NPINS; j++) begin
            on_mask[j] = (cfg_q[j].func == FN_CHASSIS_ON_SYNC);
            if (on_mask[j] && true_lvl[j]) begin
                next_on_seen = 1'b1;
            end
            if (cfg_q[j].func == FN_CHASSIS_OFF_SYNC && true_lvl[j]) begin
                next_off_seen = 1'b1;
            end
        end
        next_acq  = src_fire(acq_src, eff, edge_seen);
        next_tran = src_fire(tran_src, eff, edge_seen);
        next_inhibit = (cfg_q[INHIBIT_PIN].func == FN_INHIBIT_IN) && true_lvl[INHIBIT_PIN];
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            in_data       <= 7'h00;
            acq_trig      <= 1'b0;
            tran_trig     <= 1'b0;
            inhibit_out   <= 1'b0;
            sync_on_seen  <= 1'b0;
            sync_off_seen <= 1'b0;
        end else begin
            in_data       <= pin_in;
            acq_trig      <= next_acq;
            tran_trig     <= next_tran;
            inhibit_out   <= next_inhibit;
            sync_on_seen  <= next_on_seen;
            sync_off_seen <= next_off_seen;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_nv_restore: assert property (
        nv_load |=> nv_cfg == $past(nv_cfg_in))
        else $error("restore image not taken");

    a_fault_placement: assert property (
        (func_wr && !nv_load && wr_func == FN_FAULT_OUT && wr_pin != 3'(FAULT_PIN))
        |=> wr_reject && nv_cfg == $past(nv_cfg))
        else $error("fault accepted off pin one");

    a_on_second: assert property (
        (func_wr && !nv_load && wr_func == FN_CHASSIS_ON_SYNC && wr_pin < 3'(NPINS)
         && on_mask != 7'h00 && !on_mask[wr_pin]) |=> wr_reject && !nv_save)
        else $error("second on coupling accepted");

    a_return_lock: assert property (
        (cfg_q[FAULT_PIN].func == FN_FAULT_OUT && !nv_load && wr_pin == 3'(RETURN_PIN)
         && (func_wr || pol_wr)) |=> wr_reject && nv_cfg[RETURN_PIN] == $past(cfg_q[RETURN_PIN]))
        else $error("pin two changed under fault");

    a_return_read: assert property (
        (cfg_q[FAULT_PIN].func == FN_FAULT_OUT && rd_pin == 3'(RETURN_PIN))
        |=> rd_func == FN_FAULT_OUT)
        else $error("pin two not read as fault");

    a_return_release: assert property (
        ($past(cfg_q[FAULT_PIN].func) == FN_FAULT_OUT && cfg_q[FAULT_PIN].func != FN_FAULT_OUT
         && !$past(nv_load) && !$past(rst)) |-> cfg_q[RETURN_PIN].func == FN_INPUT_ONLY)
        else $error("pin two not set input only");

    a_data_store: assert property (
        data_wr |=> out_data == $past(data_val) ##1 (out_data == $past(data_val, 2) || $past(data_wr)))
        else $error("output data not held");

    a_in_mirror: assert property (
        !$past(rst) |-> in_data == $past(pin_in))
        else $error("input data not pin level");

    a_inhibit_out: assert property (
        (cfg_q[INHIBIT_PIN].func == FN_INHIBIT_IN && true_lvl[INHIBIT_PIN]) |=> inhibit_out)
        else $error("inhibit not raised");

    for (genvar i = 0; i < NPINS; i++) begin : g_chk
        a_gpio_drive: assert property (
            eff[i].func == FN_GENERAL_IO |=> !pin_oe_n[i]
            && pin_out[i] == ($past(out_data[i]) ^ ($past(eff[i].pol) == POL_NEGATIVE)))
            else $error("general pin drive wrong");

        a_input_float: assert property (
            eff[i].func == FN_INPUT_ONLY |=> pin_oe_n[i])
            else $error("input only pin driven");

        a_trig_level: assert property (
            (trig_fire && eff[i].func == FN_TRIGGER_OUT) |=> !pin_oe_n[i]
            && pin_out[i] == ($past(eff[i].pol) == POL_POSITIVE))
            else $error("trigger pulse level wrong");
    end

endmodule

// >>> tb/cpm_far_end.sv
// Far side of the port pins: outside equipment, pull-ups and wire resolution.
`timescale 1ns/100ps
module cpm_far_end (
    input  wire logic [6:0] pin_out,  // Device drive levels.
    input  wire logic [6:0] pin_oe_n, // Device drives when low.
    input  wire logic [6:0] ext_val,  // Outside drive levels.
    input  wire logic [6:0] ext_en,   // Outside drives when high.
    output logic      [6:0] pin_in    // Resolved wire levels.
);
    // wired coupling line
    // Each line is wire-AND with a pull-up, so a released coupling pin reads false.
    always_comb begin
        for (int i = 0; i < 7; i++) begin
            pin_in[i] = (pin_oe_n[i] | pin_out[i]) & (~ext_en[i] | ext_val[i]);
        end
    end
endmodule

// >>> tb/test_cpm_port.sv
// Self-checking bench for the control port pin function mux.
`timescale 1ns/100ps
module test_cpm_port;
    import cpm_pkg::*;
    logic         clk, rst, func_wr, pol_wr, nv_load, data_wr, bus_en_wr, bus_en_val;
    logic         bus_trg, seq_tout_en, seq_trig, local_on, local_off, wr_reject, nv_save;
    logic         bus_trg_en, acq_trig, tran_trig, inhibit_out, sync_on_seen, sync_off_seen;
    logic [2:0]   wr_pin, rd_pin, acq_src, tran_src;
    logic [3:0]   chan_prot;
    logic [6:0]   data_val, out_data, in_data, pin_in, pin_out, pin_oe_n, ext_val, ext_en;
    cpm_func_t    wr_func, rd_func;
    cpm_pol_t     wr_pol, rd_pol;
    cpm_cfg_img_t nv_cfg_in, nv_cfg, img;
    int           n_errors, compares;

    cpm_port cpm_port_inst (.clk, .rst, .func_wr, .wr_pin, .wr_func, .pol_wr, .wr_pol,
        .wr_reject, .rd_pin, .rd_func, .rd_pol, .nv_load, .nv_cfg_in, .nv_cfg, .nv_save,
        .data_wr, .data_val, .out_data, .in_data, .bus_en_wr, .bus_en_val, .bus_trg_en,
        .bus_trg, .seq_tout_en, .seq_trig, .acq_src, .tran_src, .acq_trig, .tran_trig,
        .chan_prot, .inhibit_out, .local_on, .local_off, .sync_on_seen, .sync_off_seen,
        .pin_in, .pin_out, .pin_oe_n);
    cpm_far_end cpm_far_end_inst (.pin_out, .pin_oe_n, .ext_val, .ext_en, .pin_in);

    // Free-running 50 MHz clock.
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic chk(input logic [35:0] s, input logic [35:0] e);
        compares++;
        if (s !== e) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Config write; the expected image is only advanced when the write should land.
    // The reject and save pulses stand for one cycle, so they are read right after the edge.
    task automatic cw(input logic [2:0] p, input cpm_func_t f, input cpm_pol_t q,
                      input logic df, input logic dp, input logic rej);
        wr_pin = p;
        wr_func = f;
        wr_pol = q;
        func_wr = df;
        pol_wr = dp;
        cyc(1);
        func_wr = 1'b0;
        pol_wr = 1'b0;
        if (!rej && df) img[p].func = f;
        if (!rej && dp) img[p].pol = q;
        chk({wr_reject, nv_save}, {rej, ~rej});
        chk(nv_cfg, img);
        cyc(1);
    endtask

    // Readback waits two edges so either sampling reading of rd_pin is covered.
    task automatic rd(input logic [2:0] p, input cpm_func_t f, input cpm_pol_t q);
        rd_pin = p;
        cyc(2);
        chk({rd_func, rd_pol}, {f, q});
    endtask

    // One-cycle strobe: 0 sequencer trigger, 1 bus trigger, 2 bus enable write.
    task automatic pulse(input int k);
        {bus_en_wr, bus_trg, seq_trig} = 3'h1 << k;
        cyc(1);
        {bus_en_wr, bus_trg, seq_trig} = 3'h0;
        cyc(1);
    endtask

    task automatic tally_and_finish;
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Guard against a stalled sequence.
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        tally_and_finish();
    end

    // Main sequence.
    initial begin
        {rst, func_wr, pol_wr, nv_load, data_wr, bus_en_wr, bus_en_val} = 7'h40;
        {bus_trg, seq_tout_en, seq_trig, local_on, local_off} = 5'h00;
        {wr_pin, rd_pin} = '0;
        wr_func = FN_GENERAL_IO;
        wr_pol = POL_POSITIVE;
        {data_val, ext_val, ext_en, chan_prot, nv_cfg_in} = '0;
        acq_src = SRC_NONE;
        tran_src = SRC_NONE;
        img = {7{CFG_RESET}};
        n_errors = 0;
        compares = 0;
        cyc(2);
        rst = 1'b0;
        chk({nv_cfg, out_data, bus_trg_en}, 36'h0);
        data_val = 7'h15;
        data_wr = 1'b1;
        cyc(1);
        data_wr = 1'b0;
        cyc(3);
        chk({out_data, pin_out, pin_oe_n}, {7'h15, 7'h15, 7'h00});
        chk(in_data, 7'h15);
        cw(4, FN_INPUT_ONLY, POL_POSITIVE, 1, 0, 0);
        ext_en = 7'h10;
        cyc(3);
        chk({pin_oe_n[4], in_data[4]}, 2'b10);
        cw(1, FN_FAULT_OUT, POL_POSITIVE, 1, 0, 1);
        cw(0, FN_INHIBIT_IN, POL_POSITIVE, 1, 0, 1);
        cw(0, FN_FAULT_OUT, POL_POSITIVE, 1, 0, 0);
        cw(1, FN_GENERAL_IO, POL_POSITIVE, 1, 0, 1);
        cw(1, FN_GENERAL_IO, POL_NEGATIVE, 0, 1, 1);
        rd(1, FN_FAULT_OUT, POL_POSITIVE);
        chan_prot = 4'h4;
        cyc(3);
        chk({pin_out[0], pin_oe_n[1:0]}, 3'b110);
        chan_prot = 4'h0;
        cyc(3);
        chk(pin_out[0], 1'b0);
        img[1].func = FN_INPUT_ONLY;
        cw(0, FN_GENERAL_IO, POL_POSITIVE, 1, 0, 0);
        rd(1, FN_INPUT_ONLY, POL_POSITIVE);
        cw(2, FN_INHIBIT_IN, POL_POSITIVE, 1, 0, 0);
        ext_en = 7'h14;
        ext_val = 7'h04;
        cyc(3);
        chk(inhibit_out, 1'b1);
        ext_val = 7'h00;
        cyc(3);
        chk(inhibit_out, 1'b0);
        cw(3, FN_CHASSIS_ON_SYNC, POL_POSITIVE, 1, 0, 0);
        cw(6, FN_CHASSIS_ON_SYNC, POL_POSITIVE, 1, 0, 1);
        cw(5, FN_CHASSIS_OFF_SYNC, POL_POSITIVE, 1, 0, 0);
        cw(0, FN_CHASSIS_OFF_SYNC, POL_POSITIVE, 1, 0, 1);
        local_on = 1'b1;
        cyc(4);
        chk({sync_on_seen, pin_oe_n[3], pin_out[3]}, 3'b100);
        local_on = 1'b0;
        local_off = 1'b1;
        cyc(4);
        chk({sync_on_seen, sync_off_seen, pin_oe_n[5], pin_oe_n[3]}, 4'b0101);
        local_off = 1'b0;
        cw(6, FN_TRIGGER_OUT, POL_NEGATIVE, 1, 1, 0);
        cyc(2);
        chk(pin_out[6], 1'b1);
        pulse(0);
        chk(pin_out[6], 1'b1);
        seq_tout_en = 1'b1;
        pulse(0);
        chk(pin_out[6], 1'b0);
        // Two active cycles have passed; the last active one is the width minus two later.
        cyc(TRIG_PULSE_CYC - 2);
        chk(pin_out[6], 1'b0);
        cyc(1);
        chk(pin_out[6], 1'b1);
        seq_tout_en = 1'b0;
        pulse(1);
        chk(pin_out[6], 1'b1);
        bus_en_val = 1'b1;
        pulse(2);
        chk(bus_trg_en, 1'b1);
        pulse(1);
        chk(pin_out[6], 1'b0);
        cw(4, FN_TRIGGER_IN, POL_POSITIVE, 1, 0, 0);
        acq_src = 3'h4;
        tran_src = 3'h4;
        cyc(2);
        ext_val = 7'h10;
        cyc(1);
        chk({acq_trig, tran_trig}, 2'b00);
        cyc(1);
        chk({acq_trig, tran_trig}, 2'b11);
        cyc(1);
        chk({acq_trig, tran_trig}, 2'b00);
        cw(4, FN_TRIGGER_IN, POL_NEGATIVE, 0, 1, 0);
        cyc(3);
        ext_val = 7'h00;
        cyc(2);
        chk({acq_trig, tran_trig}, 2'b11);
        for (int p = 0; p < 7; p++) rd(p, img[p].func, img[p].pol);
        nv_cfg_in = {7{4'h3}};
        nv_load = 1'b1;
        cyc(1);
        nv_load = 1'b0;
        cyc(1);
        chk(nv_cfg, {7{4'h3}});
        rd(6, FN_INPUT_ONLY, POL_NEGATIVE);
        tally_and_finish();
    end
endmodule
